// >>> test_wake_bank_cyclic_timers.sv
// Self-checking bench for the wake bank and cyclic timer core.
module test_wake_bank_cyclic_timers
  import wbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, restart_evt = 1'b0;
  logic failsafe_entry = 1'b0, failsafe_mode = 1'b0;
  logic sense_switch_cleared = 1'b0, reg_wr, wake_two_is_input;
  logic sync_input_active;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd;
  logic [1:0] timer_on_phase, cyclic_wake_evt;
  logic [3:0] wake_enable_eff;
  logic [2:0] wake_filter_eff;
  int num_errors = 0, checks = 0, cycles = 0;
  always #25 core_clk = ~core_clk;
  wbt_core dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .restart_evt(restart_evt),
    .failsafe_entry(failsafe_entry), .failsafe_mode(failsafe_mode),
    .sense_switch_cleared(sense_switch_cleared),
    .timer_on_phase(timer_on_phase), .cyclic_wake_evt(cyclic_wake_evt),
    .wake_enable_eff(wake_enable_eff), .wake_filter_eff(wake_filter_eff),
    .wake_two_is_input(wake_two_is_input),
    .sync_input_active(sync_input_active));
  wbt_host u_host (.core_clk(core_clk), .reg_rdata(reg_rdata),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_fields();
    u_host.read(ADDR_WAKE, rd);
    chk("wake_por", WAKE_POR, rd);
    u_host.read(8'h07, rd);
    chk("unmapped", 16'h0000, rd);
    u_host.write(ADDR_TIMER, 16'hFFFF);
    u_host.read(ADDR_TIMER, rd);
    chk("timer_mask", 16'hEFF7, rd);
    chk("stop_high7", 2'b11, timer_on_phase);
    u_host.write(ADDR_TIMER, 16'hC060);
    tick(2);
    chk("stop_high6", 2'b11, timer_on_phase);
    u_host.write(ADDR_TIMER, 16'h0000);
    tick(2);
    chk("stop_low", 2'b00, timer_on_phase);
  endtask
  task automatic t_on_phase();
    int n;
    logic seen;
    u_host.write_timer(16'h0090);
    n = 0;
    seen = 1'b0;
    while (timer_on_phase[0] !== 1'b1 && n < 10) begin
      seen |= cyclic_wake_evt[0];
      tick(1);
      n++;
    end
    n = 0;
    while (timer_on_phase[0] === 1'b1 && n < 3000) begin
      seen |= cyclic_wake_evt[0];
      tick(1);
      n++;
    end
    chk("on_time", 16'(ON_US[1] * US_CYCLES), 16'(n));
    chk("wake_pulse", 1'b1, seen);
    sense_switch_cleared = 1'b1;
    tick(1);
    sense_switch_cleared = 1'b0;
    u_host.read(ADDR_TIMER, rd);
    chk("sense_clear", 16'h0000, rd);
  endtask
  task automatic t_wake();
    u_host.write(ADDR_WAKE, 16'h8001);
    u_host.read(ADDR_WAKE, rd);
    chk("bank_two", 16'h8001, rd);
    u_host.write_timer(16'h0090);
    restart_evt = 1'b1;
    tick(1);
    restart_evt = 1'b0;
    u_host.read(ADDR_TIMER, rd);
    chk("restart_timer", TIMER_RESTART, rd);
    chk("fo_kept", 1'b1, wake_two_is_input);
    u_host.write(ADDR_WAKE, 16'h0043);
    u_host.write(ADDR_WAKE, 16'h2043);
    tick(2);
    chk("sync_in", 1'b1, sync_input_active);
    chk("sync_filt", FILT_SYNC, wake_filter_eff);
    failsafe_entry = 1'b1;
    tick(1);
    failsafe_entry = 1'b0;
    tick(2);
    chk("fs_enables", 4'b0111, wake_enable_eff);
    failsafe_mode = 1'b1;
    tick(2);
    chk("fs_filter", FILT_16, wake_filter_eff);
  endtask
  initial begin
    tick(16);
    rst = 1'b0;
    t_fields();
    t_on_phase();
    t_wake();
    final_report();
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
endmodule

// >>> wbt_core.sv
// Banked wake configuration and two cyclic timers with register port.
module wbt_core
  import wbt_pkg::*;
(
  // Clock and control.
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port.
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Device mode events.
  input wire logic restart_evt,
  input wire logic failsafe_entry,
  input wire logic failsafe_mode,
  input wire logic sense_switch_cleared,
  // Timer and wake outputs.
  output logic [1:0] timer_on_phase,
  output logic [1:0] cyclic_wake_evt,
  output logic [3:0] wake_enable_eff,
  output logic [2:0] wake_filter_eff,
  output logic wake_two_is_input,
  output logic sync_input_active
);


  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] bank;
    logic fo_sel;
    logic [3:0][2:0] filt;
    logic [3:0][1:0] pupd;
    logic [3:0][1:0] en;
    logic [15:0] tctl;
    logic [1:0][4:0] pre;
    logic [1:0][23:0] cnt;
    logic [1:0] on;
    logic [1:0] wake;
    logic [15:0] rdata;
    logic [3:0] en_eff;
    logic [2:0] filt_eff;
    logic wk2_in;
    logic sync_act;
  } wbt_state_t;

  wbt_state_t st;
  wbt_state_t next_st;

  logic [1:0][2:0] on_code;
  logic [1:0][2:0] per_code;
  logic [1:0] bank_ok;
  logic [15:0] wake_view;
  logic [15:0] wake_wr;
  logic [15:0] wake_kept;
  logic [2:0] filt_wr;
  logic [1:0] idx;
  logic [1:0] wr_idx;
  logic wr_ok;

  // ----------------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------------
  always_comb begin
    on_code[1] = st.tctl[T2_ON_LSB +: 3];
    on_code[0] = st.tctl[T1_ON_LSB +: 3];
    per_code[1] = st.tctl[T2_PER_LSB +: 3];
    per_code[0] = st.tctl[T1_PER_LSB +: 3];
    idx = st.bank[1:0];
    bank_ok = {1'b0, ~st.bank[2]};
    wake_view = 16'h0000;
    // Banked read of the selected input's fields.
    if (bank_ok[0]) begin
      wake_view[WAKE_FILT_LSB +: 3] = st.filt[idx];
      wake_view[10:9] = st.pupd[idx];
      wake_view[WAKE_EN_LSB +: 2] = st.en[idx];
    end
    if (st.bank == BANK_TWO) begin
      wake_view[WAKE_FO_BIT] = st.fo_sel;
    end
    wake_view[WAKE_BNK_LSB +: 3] = st.bank;
    wake_view = wake_view & WAKE_RD_MASK;
    wake_kept = wake_view & WAKE_RESTART_KEEP;
    wake_wr = reg_wdata;
    filt_wr = reg_wdata[WAKE_FILT_LSB +: 3];
    // A write routes its fields by the bank code carried in the same word.
    wr_idx = reg_wdata[1:0];
    wr_ok = ~reg_wdata[2];
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Register writes.
    if (reg_wr && reg_addr == ADDR_WAKE) begin
      next_st.bank = wake_wr[WAKE_BNK_LSB +: 3];
      if (wr_ok) begin
        next_st.pupd[wr_idx] = wake_wr[10:9];
        next_st.en[wr_idx] = wake_wr[WAKE_EN_LSB +: 2];
        // Sync filter only for input four in sync mode; else kept.
        if (filt_wr != FILT_SYNC) begin
          next_st.filt[wr_idx] = filt_wr;
        end else if (wake_wr[WAKE_BNK_LSB +: 3] == BANK_FOUR &&
                     wake_wr[WAKE_EN_LSB +: 2] == EN_SYNC) begin
          next_st.filt[wr_idx] = filt_wr;
        end
      end
      if (wake_wr[WAKE_BNK_LSB +: 3] == BANK_TWO) begin
        next_st.fo_sel = wake_wr[WAKE_FO_BIT];
      end
    end
    if (reg_wr && reg_addr == ADDR_TIMER) begin
      next_st.tctl = reg_wdata & TIMER_WR_MASK;
    end
    // Restart clears the bank select and timer control; all other wake fields are kept.
    if (restart_evt) begin
      next_st.bank = 3'h0;
      next_st.tctl = TIMER_RESTART;
    end
    if (sense_switch_cleared) begin
      next_st.tctl = TIMER_RESTART;
    end
    // Fail-safe entry forces enables on, sparing fail output and sync.
    if (failsafe_entry) begin
      for (int i = 0; i < 4; i++) begin
        if (!(i == 1 && !st.fo_sel) &&
            !(i == 3 && st.en[3] == EN_SYNC)) begin
          next_st.en[i] = EN_ON;
        end
      end
    end
    next_st.wake = 2'b00;
    // Each timer has its own microsecond prescaler so that a start is exact.
    for (int t = 0; t < 2; t++) begin
      if (on_code[t] == ON_STOP_LOW) begin
        next_st.cnt[t] = 24'h0;
        next_st.pre[t] = 5'h00;
        next_st.on[t] = 1'b0;
      end else if (on_code[t] >= ON_STOP_HIGH) begin
        next_st.cnt[t] = 24'h0;
        next_st.pre[t] = 5'h00;
        next_st.on[t] = 1'b1;
      end else begin
        // Running code starts the period with no separate start.
        if (st.pre[t] == 5'(US_CYCLES - 1)) begin
          next_st.pre[t] = 5'h00;
          if (st.cnt[t] + 24'h1 >= PER_US[per_code[t]]) begin
            next_st.cnt[t] = 24'h0;
          end else begin
            next_st.cnt[t] = st.cnt[t] + 24'h1;
          end
        end else begin
          next_st.pre[t] = st.pre[t] + 5'h01;
        end
        next_st.on[t] = st.cnt[t] < ON_US[on_code[t]];
      end
      // Wake pulse at each period start of the selected timer.
      if (st.tctl[CYC_LSB +: 2] == 2'(t + 1) && next_st.on[t] && !st.on[t] &&
          on_code[t] < ON_STOP_HIGH) begin
        next_st.wake[t] = 1'b1;
      end
    end
    // Effective per-input enables and filter.
    for (int i = 0; i < 4; i++) begin
      next_st.en_eff[i] = (st.en[i] == EN_ON);
    end
    next_st.wk2_in = st.fo_sel;
    next_st.sync_act = (st.en[3] == EN_SYNC);
    next_st.filt_eff = failsafe_mode ? FILT_16 : st.filt[idx];
    // Filter codes 010, 011, 100 select timer one, two or sync sampling.
    if (!failsafe_mode && st.filt[idx] > FILT_SYNC) begin
      next_st.filt_eff = FILT_16;
    end
    next_st.rdata = (reg_addr == ADDR_TIMER) ? st.tctl & TIMER_WR_MASK :
                    (reg_addr == ADDR_WAKE) ? wake_view : 16'h0000;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
      for (int i = 0; i < 4; i++) begin
        st.en[i] <= WAKE_POR[WAKE_EN_LSB +: 2];
      end
      st.tctl <= TIMER_POR;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = st.rdata;
  assign timer_on_phase = st.on;
  assign cyclic_wake_evt = st.wake;
  assign wake_enable_eff = st.en_eff;
  assign wake_filter_eff = st.filt_eff;
  assign wake_two_is_input = st.wk2_in;
  assign sync_input_active = st.sync_act;

endmodule

// >>> wbt_core_checker.sv
// Checker for read-back, reset and mode overrides of the wake timer core.
module wbt_core_checker
  import wbt_pkg::*;
(
  // Watched ports.
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic restart_evt,
  input wire logic failsafe_entry,
  input wire logic failsafe_mode,
  input wire logic [1:0] timer_on_phase,
  input wire logic [1:0] cyclic_wake_evt,
  input wire logic [3:0] wake_enable_eff,
  input wire logic [2:0] wake_filter_eff,
  input wire logic sync_input_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  timer_reserved_a:
    assert property ($past(clk_en) && $past(reg_addr) == ADDR_TIMER
      |-> reg_rdata[12] == 1'b0 && reg_rdata[3] == 1'b0)
    else $error("timer reserved bit set");
  unmapped_read_a:
    assert property ($past(clk_en) && $past(reg_addr) != ADDR_TIMER
      && $past(reg_addr) != ADDR_WAKE |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  restart_stop_a:
    assert property (restart_evt && clk_en ##1 clk_en
      |=> timer_on_phase == 2'b00) else $error("timer runs after restart");
  wake_pulse_a:
    assert property ($past(clk_en)
      |-> (cyclic_wake_evt & $past(cyclic_wake_evt)) == 2'b00)
    else $error("wake pulse too long");
  failsafe_en_a:
    assert property (failsafe_entry && clk_en ##1 clk_en
      |=> wake_enable_eff[0] && wake_enable_eff[2])
    else $error("enables not forced on");
  failsafe_filt_a:
    assert property (failsafe_mode && clk_en |=> wake_filter_eff == FILT_16)
    else $error("filter not static in fail-safe");
  sync_filter_a:
    assert property (wake_filter_eff == FILT_SYNC |-> sync_input_active)
    else $error("sync filter without sync input");
  reset_out_a:
    assert property (disable iff (1'b0) rst
      |=> timer_on_phase == 2'b00 && cyclic_wake_evt == 2'b00)
    else $error("outputs active in reset");
endmodule

bind wbt_core wbt_core_checker u_chk (.core_clk(core_clk), .rst(rst),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .restart_evt(restart_evt), .failsafe_entry(failsafe_entry),
  .failsafe_mode(failsafe_mode), .timer_on_phase(timer_on_phase),
  .cyclic_wake_evt(cyclic_wake_evt), .wake_enable_eff(wake_enable_eff),
  .wake_filter_eff(wake_filter_eff), .sync_input_active(sync_input_active));

// >>> wbt_host.sv
// Host model that writes and reads the block registers.
module wbt_host
  import wbt_pkg::*;
(
  // Register port.
  input wire logic core_clk,
  input wire logic [15:0] reg_rdata,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 16'h0000;
  end
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // Source and period go in before an on-time starts the timer.
  task automatic write_timer(input logic [15:0] d);
    write(ADDR_TIMER, d & 16'h1F8F);
    write(ADDR_TIMER, d);
  endtask
  task automatic read(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    d = reg_rdata;
  endtask
endmodule

// >>> wbt_pkg.sv
// Package with register layout, reset values and timing constants.
package wbt_pkg;

  localparam int unsigned CLK_HZ = 20000000;
  localparam logic [7:0] ADDR_TIMER = 8'h06;
  localparam logic [7:0] ADDR_WAKE = 8'h05;

  // Wake configuration layout and reset values.
  localparam logic [15:0] WAKE_POR = 16'h0020;
  localparam logic [15:0] WAKE_RESTART_KEEP = 16'hBE60;
  localparam logic [15:0] WAKE_RD_MASK = 16'hBE67;
  localparam int WAKE_FO_BIT = 15;
  localparam int WAKE_FILT_LSB = 11;
  localparam int WAKE_EN_LSB = 5;
  localparam int WAKE_BNK_LSB = 0;

  // Timer control layout and reset values.
  localparam logic [15:0] TIMER_POR = 16'h0000;
  localparam logic [15:0] TIMER_RESTART = 16'h0000;
  localparam logic [15:0] TIMER_WR_MASK = 16'hEFF7;
  localparam int T2_ON_LSB = 13;
  localparam int T2_PER_LSB = 9;
  localparam int CYC_LSB = 7;
  localparam int T1_ON_LSB = 4;
  localparam int T1_PER_LSB = 0;

  // Codes.
  localparam logic [2:0] BANK_TWO = 3'h1;
  localparam logic [2:0] BANK_FOUR = 3'h3;
  localparam logic [1:0] EN_ON = 2'h1;
  localparam logic [1:0] EN_SYNC = 2'h2;
  localparam logic [2:0] FILT_16 = 3'h0;
  localparam logic [2:0] FILT_SYNC = 3'h4;
  localparam logic [2:0] ON_STOP_LOW = 3'h0;
  localparam logic [2:0] ON_STOP_HIGH = 3'h6;

  // Times in microseconds and the derived one-microsecond prescale.
  localparam int unsigned US_CYCLES = CLK_HZ / 1000000;
  localparam int unsigned SETTLE_US = 80;
  localparam int unsigned SENSE_FILT_US = 16;
  localparam logic [23:0] ON_US [8] = '{24'h0, 24'd100, 24'd300, 24'd1000,
    24'd10000, 24'd20000, 24'h0, 24'h0};
  localparam logic [23:0] PER_US [8] = '{24'd10000, 24'd20000, 24'd50000,
    24'd100000, 24'd200000, 24'd500000, 24'd1000000, 24'd2000000};

endpackage
